// file: mvi_regs.vh
`ifndef MVI_REGS_VH
`define MVI_REGS_VH

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define MVI_NUM_SRC    31
`define MVI_NUM_VEC    10
`define MVI_NUM_XVEC   2
`define MVI_NUM_PIN    5
`define MVI_IDX_W      4
`define MVI_VEC_W      17
`define MVI_MASK_W     3
`define MVI_FILL_W     2

// ----------------------------------------------------------------------
// Vector addresses: base plus eight bytes per vector number
// ----------------------------------------------------------------------
`define MVI_VEC_BASE   17'h00003
`define MVI_VEC_SHIFT  3

// ----------------------------------------------------------------------
// Level codes, ordered so that a larger code is a higher level
// ----------------------------------------------------------------------
`define MVI_LVL_NONE   2'h0
`define MVI_LVL_LOW    2'h1
`define MVI_LVL_HIGH   2'h2
`define MVI_LVL_TOP    2'h3

// In-service mask bits, one per level.
`define MVI_MSK_LOW    3'h1
`define MVI_MSK_HIGH   3'h2
`define MVI_MSK_TOP    3'h4
`define MVI_MSK_NONE   3'h0
`define MVI_BIT_LOW    0
`define MVI_BIT_HIGH   1
`define MVI_BIT_TOP    2

// ----------------------------------------------------------------------
// Source bit positions on the request vector
// ----------------------------------------------------------------------
`define MVI_V0_LO      0
`define MVI_V0_HI      0
`define MVI_V1_LO      1
`define MVI_V1_HI      1
`define MVI_V2_LO      2
`define MVI_V2_HI      6
`define MVI_V3_LO      7
`define MVI_V3_HI      10
`define MVI_V4_LO      11
`define MVI_V4_HI      13
`define MVI_V5_LO      14
`define MVI_V5_HI      17
`define MVI_V6_LO      18
`define MVI_V6_HI      20
`define MVI_V7_LO      21
`define MVI_V7_HI      23
`define MVI_V8_LO      24
`define MVI_V8_HI      26
`define MVI_V9_LO      27
`define MVI_V9_HI      30

`define MVI_SRC_IR     6
`define MVI_SRC_BT0    9
`define MVI_SRC_BT1    10
`define MVI_SRC_PORT0  27

`endif

// file: mvi_prio_enc.v
`timescale 1ns/1ps
`include "mvi_regs.vh"

// Lowest set bit wins, which gives the smallest vector address.
module mvi_prio_enc #(
  parameter N = `MVI_NUM_VEC
) (
  input  wire [N-1:0]          req,
  output reg  [`MVI_IDX_W-1:0] idx,
  output reg                   any
);

  integer i;

  always @* begin
    idx = {`MVI_IDX_W{1'b0}};
    any = 1'b0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        idx = i[`MVI_IDX_W-1:0];
        any = 1'b1;
      end
    end
  end

endmodule // mvi_prio_enc

// file: mvi_ctrl.v
`timescale 1ns/1ps
`include "mvi_regs.vh"

module mvi_ctrl (
  input  wire                    clk,
  input  wire                    rst,
  input  wire [`MVI_NUM_SRC-1:0] src_req,
  input  wire [`MVI_NUM_VEC-1:0] lvl_sel,
  input  wire                    irq_ack,
  input  wire                    irq_reti,
  input  wire                    halt_enter,
  input  wire                    hold_enter,
  input  wire                    xhold_enter,
  input  wire                    ext_irq_pin_a,
  input  wire                    ext_irq_pin_b,
  input  wire                    ext_irq_pin_c,
  input  wire                    ext_irq_pin_e,
  input  wire                    ext_irq_pin_f,
  input  wire [`MVI_NUM_PIN-1:0] ext_act_lvl,
  output reg                     irq_req,
  output reg  [`MVI_VEC_W-1:0]   irq_vec,
  output reg  [1:0]              irq_lvl,
  output reg  [`MVI_MASK_W-1:0]  svc_mask,
  output reg                     halt_mode,
  output reg                     hold_mode,
  output reg                     xhold_mode
);

  // --------------------------------------------------------------------
  // Source merge
  // --------------------------------------------------------------------
  // Peripheral flags are levels held until software clears them, so a
  // vector stays pending as long as any of its sources is set.
  wire [`MVI_NUM_VEC-1:0] pend;

  assign pend[0] = |src_req[`MVI_V0_HI:`MVI_V0_LO];
  assign pend[1] = |src_req[`MVI_V1_HI:`MVI_V1_LO];
  assign pend[2] = |src_req[`MVI_V2_HI:`MVI_V2_LO];
  assign pend[3] = |src_req[`MVI_V3_HI:`MVI_V3_LO];
  assign pend[4] = |src_req[`MVI_V4_HI:`MVI_V4_LO];
  assign pend[5] = |src_req[`MVI_V5_HI:`MVI_V5_LO];
  assign pend[6] = |src_req[`MVI_V6_HI:`MVI_V6_LO];
  assign pend[7] = |src_req[`MVI_V7_HI:`MVI_V7_LO];
  assign pend[8] = |src_req[`MVI_V8_HI:`MVI_V8_LO];
  assign pend[9] = |src_req[`MVI_V9_HI:`MVI_V9_LO];

  // --------------------------------------------------------------------
  // In-service level
  // --------------------------------------------------------------------
  // Nested levels are strictly rising, so one bit per level is a full
  // stack: the top set bit is the level in service.
  reg [1:0]             cur_lvl;
  reg [`MVI_MASK_W-1:0] top_bit;

  always @* begin
    if (svc_mask[`MVI_BIT_TOP]) begin
      cur_lvl = `MVI_LVL_TOP;
      top_bit = `MVI_MSK_TOP;
    end else if (svc_mask[`MVI_BIT_HIGH]) begin
      cur_lvl = `MVI_LVL_HIGH;
      top_bit = `MVI_MSK_HIGH;
    end else if (svc_mask[`MVI_BIT_LOW]) begin
      cur_lvl = `MVI_LVL_LOW;
      top_bit = `MVI_MSK_LOW;
    end else begin
      cur_lvl = `MVI_LVL_NONE;
      top_bit = `MVI_MSK_NONE;
    end
  end

  // --------------------------------------------------------------------
  // Level assignment and acceptance
  // --------------------------------------------------------------------
  wire [1:0]              vec_lvl [0:`MVI_NUM_VEC-1];
  wire [`MVI_NUM_VEC-1:0] ok_top;
  wire [`MVI_NUM_VEC-1:0] ok_high;
  wire [`MVI_NUM_VEC-1:0] ok_low;

  genvar g;
  generate
    for (g = 0; g < `MVI_NUM_VEC; g = g + 1) begin : g_vec
      // Only the first two vectors may be raised to the top level.
      assign vec_lvl[g] = !lvl_sel[g] ? `MVI_LVL_LOW :
                          (g < `MVI_NUM_XVEC) ? `MVI_LVL_TOP :
                          `MVI_LVL_HIGH;
      // Codes are ordered, so a plain compare ranks the levels.
      assign ok_top[g]  = pend[g] && (vec_lvl[g] > cur_lvl) &&
                          (vec_lvl[g] == `MVI_LVL_TOP);
      assign ok_high[g] = pend[g] && (vec_lvl[g] > cur_lvl) &&
                          (vec_lvl[g] == `MVI_LVL_HIGH);
      assign ok_low[g]  = pend[g] && (vec_lvl[g] > cur_lvl) &&
                          (vec_lvl[g] == `MVI_LVL_LOW);
    end
  endgenerate

  // --------------------------------------------------------------------
  // Arbitration
  // --------------------------------------------------------------------
  wire [`MVI_IDX_W-1:0] idx_top;
  wire [`MVI_IDX_W-1:0] idx_high;
  wire [`MVI_IDX_W-1:0] idx_low;
  wire                  any_top;
  wire                  any_high;
  wire                  any_low;

  mvi_prio_enc #(.N(`MVI_NUM_VEC)) u_enc_top (
    .req (ok_top),
    .idx (idx_top),
    .any (any_top)
  );

  mvi_prio_enc #(.N(`MVI_NUM_VEC)) u_enc_high (
    .req (ok_high),
    .idx (idx_high),
    .any (any_high)
  );

  mvi_prio_enc #(.N(`MVI_NUM_VEC)) u_enc_low (
    .req (ok_low),
    .idx (idx_low),
    .any (any_low)
  );

  reg [`MVI_IDX_W-1:0] win_idx;
  reg [1:0]            win_lvl;
  reg                  win_any;

  always @* begin
    if (any_top) begin
      win_idx = idx_top;
      win_lvl = `MVI_LVL_TOP;
      win_any = 1'b1;
    end else if (any_high) begin
      win_idx = idx_high;
      win_lvl = `MVI_LVL_HIGH;
      win_any = 1'b1;
    end else begin
      win_idx = idx_low;
      win_lvl = `MVI_LVL_LOW;
      win_any = any_low;
    end
  end

  wire [`MVI_VEC_W-1:0] next_vec;

  assign next_vec = `MVI_VEC_BASE +
                    ({{(`MVI_VEC_W-`MVI_IDX_W){1'b0}}, win_idx}
                     << `MVI_VEC_SHIFT);

  // --------------------------------------------------------------------
  // Core handshake and in-service stack
  // --------------------------------------------------------------------
  reg [`MVI_MASK_W-1:0] push_bit;
  reg [`MVI_MASK_W-1:0] pop_bit;
  wire                  take;

  assign take = irq_ack && irq_req;

  always @* begin
    case (irq_lvl)
      `MVI_LVL_TOP:  push_bit = `MVI_MSK_TOP;
      `MVI_LVL_HIGH: push_bit = `MVI_MSK_HIGH;
      `MVI_LVL_LOW:  push_bit = `MVI_MSK_LOW;
      default:       push_bit = `MVI_MSK_NONE;
    endcase
    pop_bit = irq_reti ? top_bit : `MVI_MSK_NONE;
  end

  // The request drops for the cycle after an acknowledge so that the
  // core never sees the just-granted vector twice before the mask moves.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_req  <= 1'b0;
      irq_vec  <= `MVI_VEC_BASE;
      irq_lvl  <= `MVI_LVL_NONE;
      svc_mask <= `MVI_MSK_NONE;
    end else begin
      irq_req  <= win_any && !irq_ack;
      irq_vec  <= next_vec;
      irq_lvl  <= win_any ? win_lvl : `MVI_LVL_NONE;
      svc_mask <= (svc_mask & ~pop_bit) |
                  (take ? push_bit : `MVI_MSK_NONE);
    end
  end

  // --------------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------------
  // A cleared synchroniser reads as an active-low pin, so its output is
  // ignored until two edges have filled it with real pin levels.
  reg [`MVI_NUM_PIN-1:0] pin_meta;
  reg [`MVI_NUM_PIN-1:0] pin_sync;
  reg [`MVI_FILL_W-1:0]  pin_fill;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta <= {`MVI_NUM_PIN{1'b0}};
      pin_sync <= {`MVI_NUM_PIN{1'b0}};
      pin_fill <= {`MVI_FILL_W{1'b0}};
    end else begin
      pin_meta <= {ext_irq_pin_f, ext_irq_pin_e, ext_irq_pin_c,
                   ext_irq_pin_b, ext_irq_pin_a};
      pin_sync <= pin_meta;
      pin_fill <= {pin_fill[`MVI_FILL_W-2:0], 1'b1};
    end
  end

  // --------------------------------------------------------------------
  // Standby release
  // --------------------------------------------------------------------
  wire any_raised;
  wire pin_wake;
  wire hold_wake;
  wire xhold_wake;

  assign any_raised = |pend;
  assign pin_wake   = pin_fill[`MVI_FILL_W-1] &&
                      |(pin_sync ~^ ext_act_lvl);
  assign hold_wake  = pin_wake || src_req[`MVI_SRC_PORT0];
  assign xhold_wake = hold_wake || src_req[`MVI_SRC_BT0] ||
                      src_req[`MVI_SRC_BT1] ||
                      src_req[`MVI_SRC_IR];

  // A release present on the entry cycle wins, so a wake source is
  // never lost behind a late standby command. Reset clears all modes.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      halt_mode  <= 1'b0;
      hold_mode  <= 1'b0;
      xhold_mode <= 1'b0;
    end else begin
      halt_mode  <= !any_raised && (halt_mode || halt_enter);
      hold_mode  <= !hold_wake && (hold_mode || hold_enter);
      xhold_mode <= !xhold_wake && (xhold_mode || xhold_enter);
    end
  end

endmodule // mvi_ctrl

// file: mvi_ctrl_sva.sv
`timescale 1ns/1ps
module mvi_ctrl_chk (
  input wire        clk,
  input wire        rst,
  input wire [30:0] src_req,
  input wire        irq_ack,
  input wire        ext_irq_pin_a,
  input wire [4:0]  ext_act_lvl,
  input wire        irq_req,
  input wire [16:0] irq_vec,
  input wire [1:0]  irq_lvl,
  input wire [2:0]  svc_mask,
  input wire        halt_mode,
  input wire        hold_mode,
  input wire        xhold_mode
);
  // --------------------
  // Handshake and wakes
  // --------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [1:0] top_lvl = svc_mask[2] ? 2'h3 :
                       svc_mask[1] ? 2'h2 : {1'b0, svc_mask[0]};
  property p_ack_drop; irq_ack && irq_req |=> !irq_req; endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("req after ack");
  property p_ack_push;
    irq_ack && irq_req && irq_lvl != 2'h0 |=> svc_mask[$past(irq_lvl) - 2'h1];
  endproperty
  a_ack_push: assert property (p_ack_push)
    else $error("level not pushed");
  property p_block; irq_req |-> irq_lvl > top_lvl; endproperty
  a_block: assert property (p_block)
    else $error("blocked level passed");
  property p_lvl_map;
    irq_req |-> irq_lvl != 2'h0 &&
      (irq_vec < 17'h00013 ? irq_lvl != 2'h2 : irq_lvl != 2'h3);
  endproperty
  a_lvl_map: assert property (p_lvl_map)
    else $error("bad level");
  property p_vec_addr;
    irq_req |-> irq_vec[2:0] == 3'h3 && irq_vec <= 17'h0004B;
  endproperty
  a_vec_addr: assert property (p_vec_addr)
    else $error("bad vector");
  property p_halt_wake; halt_mode && |src_req |=> !halt_mode; endproperty
  a_halt_wake: assert property (p_halt_wake)
    else $error("halt kept");
  property p_hold_pin;
    (ext_irq_pin_a == ext_act_lvl[0]) [*4] |-> !hold_mode && !xhold_mode;
  endproperty
  a_hold_pin: assert property (p_hold_pin)
    else $error("pin wake lost");
  property p_port0;
    (hold_mode || xhold_mode) && src_req[27] |=> !hold_mode && !xhold_mode;
  endproperty
  a_port0: assert property (p_port0)
    else $error("port wake lost");
  property p_xhold;
    xhold_mode && (src_req[6] || src_req[9] || src_req[10]) |=> !xhold_mode;
  endproperty
  a_xhold: assert property (p_xhold)
    else $error("xhold kept");
  c_ack: cover property (irq_ack && irq_req);
  c_full: cover property (svc_mask == 3'h7);
  c_wake: cover property ($fell(hold_mode));
endmodule // mvi_ctrl_chk

bind mvi_ctrl mvi_ctrl_chk chk (.clk, .rst, .src_req, .irq_ack,
  .ext_irq_pin_a, .ext_act_lvl, .irq_req, .irq_vec, .irq_lvl,
  .svc_mask, .halt_mode, .hold_mode, .xhold_mode);

// file: mvi_core_model.sv
`timescale 1ns/1ps
// --------------------
// Core side model
// --------------------
// Acks a waiting request dly+1 cycles after it appears; returns when told to.
module mvi_core_model (
  input  wire       clk,
  input  wire       rst,
  input  wire       irq_req,
  input  wire       en,
  input  wire [3:0] dly,
  input  wire       ret_go,
  output reg        irq_ack,
  output reg        irq_reti
);
  reg [3:0] cnt;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ack  <= 1'b0;
      irq_reti <= 1'b0;
      cnt      <= 4'h0;
    end else begin
      irq_reti <= ret_go;
      irq_ack  <= 1'b0;
      if (irq_ack || !irq_req || !en)
        cnt <= 4'h0;
      else if (cnt == dly)
        irq_ack <= 1'b1;
      else
        cnt <= cnt + 4'h1;
    end
  end
endmodule // mvi_core_model

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  reg         clk, rst, en, ret_go;
  reg         halt_enter, hold_enter, xhold_enter;
  reg  [30:0] src_req;
  reg  [9:0]  lvl_sel;
  reg  [4:0]  pins, ext_act_lvl;
  reg  [3:0]  dly;
  wire        irq_ack, irq_reti, irq_req;
  wire        halt_mode, hold_mode, xhold_mode;
  wire [16:0] irq_vec;
  wire [1:0]  irq_lvl;
  wire [2:0]  svc_mask;
  integer     bad_count, checks_done, i, k;
  localparam [39:0] SEL = {10'h202, 10'h204, 10'h200, 10'h000};
  localparam [31:0] VEC = {8'h0B, 8'h13, 8'h4B, 8'h03};
  localparam [7:0]  LVL = {2'h3, 2'h2, 2'h2, 2'h1};
  localparam [11:0] RMSK = {3'h0, 3'h0, 3'h1, 3'h3};

  mvi_ctrl uut (.clk(clk), .rst(rst), .src_req(src_req),
    .lvl_sel(lvl_sel), .irq_ack(irq_ack), .irq_reti(irq_reti),
    .halt_enter(halt_enter), .hold_enter(hold_enter),
    .xhold_enter(xhold_enter), .ext_irq_pin_a(pins[0]),
    .ext_irq_pin_b(pins[1]), .ext_irq_pin_c(pins[2]),
    .ext_irq_pin_e(pins[3]), .ext_irq_pin_f(pins[4]),
    .ext_act_lvl(ext_act_lvl), .irq_req(irq_req), .irq_vec(irq_vec),
    .irq_lvl(irq_lvl), .svc_mask(svc_mask), .halt_mode(halt_mode),
    .hold_mode(hold_mode), .xhold_mode(xhold_mode));
  mvi_core_model core (.clk(clk), .rst(rst), .irq_req(irq_req),
    .en(en), .dly(dly), .ret_go(ret_go), .irq_ack(irq_ack),
    .irq_reti(irq_reti));

  // --------------------
  // Helpers
  // --------------------
  task check(input [8*6:1] name, input [16:0] seen, input [16:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value %0s exp %h seen %h", name, exp, seen);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Polls at the rising edge so the ack seen is the one the unit takes.
  task take;
    begin
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (irq_ack !== 1'b1 && k < 20);
      check("ack", irq_ack, 17'h1);
      @(negedge clk);
    end
  endtask
  function [16:0] vec_of(input integer b);
    vec_of = 17'h3 + 17'h8 * ((b >= 1) + (b >= 2) + (b >= 7) + (b >= 11)
             + (b >= 14) + (b >= 18) + (b >= 21) + (b >= 24) + (b >= 27));
  endfunction
  function mode_of(input integer m);
    mode_of = (m == 0) ? halt_mode : (m == 1) ? hold_mode : xhold_mode;
  endfunction
  task give_verdict;
    begin
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task t_map;
    for (i = 0; i < 31; i = i + 1) begin
      src_req = 31'h1 << i;
      tick(2);
      check("vec", irq_vec, vec_of(i));
      check("lvl", irq_lvl, 17'h1);
    end
  endtask
  task t_arb;
    begin
      src_req = 31'h7FFFFFFF;
      for (i = 0; i < 4; i = i + 1) begin
        lvl_sel = SEL[i*10 +: 10];
        tick(2);
        check("vec", irq_vec, {9'h0, VEC[i*8 +: 8]});
        check("lvl", irq_lvl, {15'h0, LVL[i*2 +: 2]});
      end
      src_req = 31'h0;
      lvl_sel = 10'h000;
      tick(2);
    end
  endtask
  task t_nest;
    begin
      en = 1'b1;
      src_req = 31'h00000004;
      take;
      tick(2);
      check("req", irq_req, 17'h0);
      check("mask", svc_mask, 17'h1);
      src_req = 31'h08000004;
      tick(2);
      check("req", irq_req, 17'h0);
      dly = 4'h3;
      lvl_sel = 10'h200;
      take;
      check("mask", svc_mask, 17'h3);
      lvl_sel = 10'h201;
      src_req = 31'h08000005;
      take;
      check("mask", svc_mask, 17'h7);
      en = 1'b0;
      // The fourth return meets an empty mask and must change nothing.
      for (k = 0; k < 4; k = k + 1) begin
        ret_go = 1'b1;
        tick(1);
        ret_go = 1'b0;
        tick(2);
        check("mask", svc_mask, {14'h0, RMSK[k*3 +: 3]});
      end
      src_req = 31'h0;
      lvl_sel = 10'h000;
      tick(2);
    end
  endtask
  // Pins must sit idle long enough to clear the synchroniser first.
  task stby(input integer m, input [30:0] ws, input [4:0] wp, input e);
    begin
      src_req = 31'h0;
      pins = 5'h01;
      tick(4);
      halt_enter = (m == 0);
      hold_enter = (m == 1);
      xhold_enter = (m == 2);
      tick(1);
      halt_enter = 1'b0;
      hold_enter = 1'b0;
      xhold_enter = 1'b0;
      tick(1);
      check("mode", mode_of(m), 17'h1);
      src_req = ws;
      pins = pins ^ wp;
      tick(4);
      check("mode", mode_of(m), {16'h0, e});
    end
  endtask
  task t_sleep;
    begin
      stby(0, 31'h00004000, 5'h0, 1'b0);
      stby(1, 31'h08000000, 5'h0, 1'b0);
      for (i = 0; i < 5; i = i + 1)
        stby(1, 31'h0, 5'h1 << i, 1'b0);
      stby(2, 31'h00000040, 5'h0, 1'b0);
      stby(2, 31'h00000200, 5'h0, 1'b0);
      stby(2, 31'h00000400, 5'h0, 1'b0);
      stby(1, 31'h00000200, 5'h0, 1'b1);
      rst = 1'b1;
      tick(1);
      rst = 1'b0;
      tick(1);
      check("mode", hold_mode, 17'h0);
      // An idle pin must not look active while the synchroniser refills.
      hold_enter = 1'b1;
      tick(1);
      hold_enter = 1'b0;
      tick(1);
      check("mode", hold_mode, 17'h1);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial begin
    bad_count = 0;
    checks_done = 0;
    {rst, en, ret_go, dly} = {3'b100, 4'h0};
    {halt_enter, hold_enter, xhold_enter} = 3'b000;
    src_req = 31'h0;
    lvl_sel = 10'h000;
    pins = 5'h01;
    ext_act_lvl = 5'h1E;
    tick(5);
    rst = 1'b0;
    tick(1);
    check("vec", irq_vec, 17'h00003);
    check("mask", svc_mask, 17'h0);
    check("req", irq_req, 17'h0);
    t_map;
    t_arb;
    t_nest;
    t_sleep;
    give_verdict;
  end
endmodule // testbench
